// ===== dv/gpcd_board.sv
/* Board model: resolves each pin from all drivers.
 Assumes the bench keeps ext_en off where the block drives. */
`timescale 1ns/1ns
module gpcd_board (
	input wire logic pclk,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] pin_pullup,
	input wire logic [3:0] ext_en,
	input wire logic [3:0] ext_val,
	output logic [3:0] pin_in
);
	logic [3:0] last = 4'h0;
	always_ff @(posedge pclk)
		last <= pin_in;
	// A floating pin without pull-up flips each cycle so no stale level passes
	always_comb begin
		for (int i = 0; i < 4; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pin_pullup[i] | ~last[i];
	end
endmodule // gpcd_board

// ===== dv/gpcd_monitor.sv
/* Checker for gpcd_top, bound in the bench.
 Assumes config changes only by APB writes. */
`timescale 1ns/1ns
module gpcd_monitor #(
	parameter int PIN_COUNT = 4,
	parameter int DIV_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic ext_reset_n,
	input wire logic bus_suspend_req,
	input wire logic suspend_active,
	input wire logic [PIN_COUNT-1:0] pin_out,
	input wire logic [PIN_COUNT-1:0] pin_oe,
	input wire logic [PIN_COUNT-1:0] pin_pullup,
	input wire logic [PIN_COUNT-1:0] pin_drive_strong
);
	// ==========================================================
	// Config shadow
	logic [1:0] ok;
	logic [2:0] quiet;
	logic [PIN_COUNT-1:0] od, pu, inv, ds, own;
	logic [DIV_W-1:0] dv;
	logic flt, alw, wr, pw, st;
	logic [1:0] ix;
	assign wr = psel && penable && pwrite;
	assign pw = wr && paddr < 8'h10;
	assign ix = paddr[3:2];
	assign st = quiet == 3'h7;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ok <= 2'b00;
		else
			ok <= {ok[0], ext_reset_n};
	end
	// Outputs lag config, so checks wait for a quiet spell
	always_ff @(posedge pclk) begin
		if (!ok[1] || wr || bus_suspend_req || suspend_active)
			quiet <= 3'h0;
		else if (!st)
			quiet <= quiet + 3'h1;
	end
	always_ff @(posedge pclk) begin
		if (!ok[1]) begin
			{od, pu, inv, ds, own} <= '0;
			{dv, flt, alw} <= {8'hff, 2'b01};
		end else if (pw && !pslverr) begin
			od[ix] <= pwdata[2];
			pu[ix] <= pwdata[3];
			inv[ix] <= pwdata[4];
			ds[ix] <= pwdata[5];
			own[ix] <= pwdata[6];
		end else if (wr && paddr == 8'h10 && !pslverr) begin
			{flt, alw} <= {pwdata[8], pwdata[9]};
			dv <= pwdata[7:0];
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ok[1]);
	a_od_low_only: assert property (
		st |-> (pin_oe & od & pin_out) == '0)
		else $error("open-drain pin driven high");
	a_pad_config: assert property (
		st |-> {pin_pullup, pin_drive_strong} == {pu, ds})
		else $error("pull-up or strength wrong");
	a_clk_one_pin: assert property (
		pw && pwdata[6] && (own & ~(4'h1 << ix)) != '0 |-> pslverr)
		else $error("second clock pin accepted");
	a_clk_pin_only: assert property (
		pw && pwdata[6] && !gpcd_pkg::CLK_CAPABLE[ix] |-> pslverr)
		else $error("clock on wrong pin accepted");
	a_susp_keep: assert property (
		suspend_active && $past(suspend_active) && !flt
		|-> $stable(pin_out) && $stable(pin_oe))
		else $error("pins moved in suspend");
	a_susp_float: assert property (
		suspend_active && $past(suspend_active) && flt
		|-> pin_oe == '0)
		else $error("pin driven in float suspend");
	a_susp_follow: assert property (
		1 |=> suspend_active == $past(bus_suspend_req && alw))
		else $error("suspend state wrong");
	// Open-drain owners cannot show a high, so they are left out
	a_clk_low_zero: assert property (
		st && dv == 8'h00 |-> ((pin_out ^ inv) & own & ~od) == '0)
		else $error("clock not held low");
	a_clk_high_ff: assert property (
		st && dv == 8'hff
		|-> ((pin_out ^ inv) & own & ~od) == (own & ~od))
		else $error("clock not held high");
	a_reset_quiet: assert property (
		@(posedge pclk) disable iff (1'b0)
		!presetn |-> pin_oe == '0 && !suspend_active)
		else $error("outputs active in reset");
	c_susp: cover property (suspend_active && $past(suspend_active));
	c_refused: cover property (pw && pslverr);
	c_clk_run: cover property (st && own != '0 && dv == 8'h01);
endmodule // gpcd_monitor

// ===== dv/tb.sv
/* Self-checking bench for gpcd_top.
 Assumes gpcd_board stands for the pins' far side. */
`timescale 1ns/1ns
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic ext_reset_n, src_tick, bus_suspend_req, suspend_active, dr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic [3:0] pin_in, pin_out, pin_oe, pin_pullup, pin_drive_strong;
	logic [3:0] ext_en, ext_val, eo, ev, ep, es, ei;
	logic [6:0] cfg [4] = '{7'h00, 7'h00, 7'h00, 7'h00};
	int error_cnt, tests_run, ph;
	int dl[4] = '{1, 2, 5, 254};
	gpcd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_reset_n(ext_reset_n), .src_tick(src_tick),
		.bus_suspend_req(bus_suspend_req), .suspend_active(suspend_active),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .pin_drive_strong(pin_drive_strong));
	gpcd_board i_board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin_in));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// 24 MHz source as ticks of the 50 MHz clock
	always @(posedge pclk) begin
		src_tick <= ph >= 26;
		ph <= ph >= 26 ? ph - 26 : ph + 24;
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string s, input logic [31:0] x, g);
		tests_run++;
		if (g !== x) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic e);
		int t;
		t = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		// A missing answer counts as a mismatch
		chk("pready", 1'b1, pready);
		r = prdata;
		chk("pslverr", e, pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic hold(input logic l);
		logic x;
		x = 1'b1;
		repeat (6) @(posedge pclk);
		repeat (40) begin
			@(posedge pclk);
			x = x && pin_out[0] === l;
		end
		chk("clock level", 1'b1, x);
	endtask
	task automatic period(input int d);
		int t, k;
		logic p;
		{t, k} = 0;
		bus(1'b1, 8'h10, 32'h200 | d, 1'b0);
		p = pin_out[0];
		repeat (1800) begin
			@(posedge pclk);
			k += int'(pin_out[0] && !p);
			t += int'(k == 2 && src_tick);
			p = pin_out[0];
		end
		chk("clock period", d + 1, t);
	endtask
	initial begin
		#600000;
		error_cnt++;
		finish_test();
	end
	// ==========================================================
	// Tests
	initial begin
		{presetn, psel, penable, pwrite, bus_suspend_req} = '0;
		// External reset pin released from the start
		ext_reset_n = 1'b1;
		{paddr, pwdata, ext_en, ext_val} = '0;
		void'($urandom(84));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		bus(1'b0, 8'h10, 0, 0);
		chk("misc reset", 32'h2ff, r);
		bus(1'b0, 8'h00, 0, 0);
		chk("pin reset", 0, r);
		bus(1'b0, 8'h18, 0, 1);
		bus(1'b1, 8'h14, 0, 1);
		$display("reset test done");
		for (int k = 0; k < 12; k++) begin
			v = $urandom & 32'h3f;
			cfg[k % 4] = v[6:0];
			bus(1'b1, 8'(k % 4 * 4), v, 1'b0);
			for (int j = 0; j < 4; j++) begin
				dr = cfg[j][1] ^ cfg[j][4];
				eo[j] = cfg[j][0] && !(cfg[j][2] && dr);
				ev[j] = dr && !cfg[j][2];
				{ep[j], ei[j], es[j]} = {cfg[j][3], cfg[j][4], cfg[j][5]};
			end
			ext_val <= 4'($urandom);
			ext_en <= ~eo;
			repeat (3) @(posedge pclk);
			chk("oe", eo, pin_oe);
			chk("out", ev & eo, pin_out & pin_oe);
			chk("pullup", ep, pin_pullup);
			chk("drive", es, pin_drive_strong);
			bus(1'b0, 8'h14, 0, 0);
			chk("read", ((eo & ev) | (~eo & ext_val)) ^ ei, r[3:0]);
		end
		$display("pin test done");
		ext_en <= 4'h0;
		bus(1'b1, 8'h04, 32'h40, 1'b1);
		bus(1'b1, 8'h00, 32'h40, 1'b0);
		bus(1'b1, 8'h08, 32'h40, 1'b1);
		bus(1'b1, 8'h10, 32'h200, 1'b0);
		hold(1'b0);
		bus(1'b1, 8'h10, 32'h2ff, 1'b0);
		hold(1'b1);
		foreach (dl[m])
			period(dl[m]);
		bus(1'b1, 8'h00, 32'h0, 1'b0);
		bus(1'b1, 8'h08, 32'h40, 1'b0);
		$display("clock test done");
		bus(1'b1, 8'h04, 32'h3, 1'b0);
		bus_suspend_req <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("suspend", 2'b11, {suspend_active, pin_oe[1]});
		bus_suspend_req <= 1'b0;
		bus(1'b1, 8'h10, 32'h3ff, 1'b0);
		bus_suspend_req <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("float", 0, pin_oe);
		bus_suspend_req <= 1'b0;
		bus(1'b1, 8'h10, 32'h0ff, 1'b0);
		bus_suspend_req <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("no suspend", 0, suspend_active);
		bus_suspend_req <= 1'b0;
		$display("suspend test done");
		ext_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		bus(1'b0, 8'h14, 0, 0);
		chk("held", 0, r[6]);
		ext_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		bus(1'b0, 8'h04, 0, 0);
		chk("ext reset", 0, r);
		$display("reset pin test done");
		finish_test();
	end
endmodule // tb
bind gpcd_top gpcd_monitor #(.PIN_COUNT(PIN_COUNT), .DIV_W(DIV_W)) i_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.ext_reset_n(ext_reset_n), .bus_suspend_req(bus_suspend_req),
	.suspend_active(suspend_active), .pin_out(pin_out), .pin_oe(pin_oe),
	.pin_pullup(pin_pullup), .pin_drive_strong(pin_drive_strong));

// ===== inc/gpcd_pkg.sv
/*
 Constants for the pin configuration and clock output block:
 register offsets, field positions, reset values and pin roles.
 Assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
package gpcd_pkg;
	// ==========================================================
	// Sizes
	localparam int PIN_COUNT = 4;
	localparam int ADDR_W = 8;
	localparam int DIV_W = 8;
	localparam int SRC_FREQ_MHZ = 24;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_PIN_BASE = 8'h00;
	localparam logic [7:0] OFS_MISC = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ==========================================================
	// Per-pin configuration fields
	localparam int PC_DIR_OUT = 0;
	localparam int PC_OUT_VAL = 1;
	localparam int PC_OPEN_DRAIN = 2;
	localparam int PC_PULLUP = 3;
	localparam int PC_INVERT = 4;
	localparam int PC_DRIVE_HI = 5;
	localparam int PC_CLK_SEL = 6;
	localparam int PC_W = 7;
	localparam logic [6:0] PIN_CFG_RST = 7'h00;

	// ==========================================================
	// Miscellaneous fields
	localparam int MC_DIV_LSB = 0;
	localparam int MC_SUSP_FLOAT = 8;
	localparam int MC_SUSP_ALLOW = 9;
	localparam logic [7:0] DIV_RST = 8'hff;
	localparam logic SUSP_FLOAT_RST = 1'b0;
	localparam logic SUSP_ALLOW_RST = 1'b1;

	// ==========================================================
	// Status fields
	localparam int ST_PIN_LSB = 0;
	localparam int ST_SUSPENDED = 4;
	localparam int ST_CLK_LEVEL = 5;
	localparam int ST_RUNNING = 6;

	// Pins able to carry the divided clock: index 0 and index 2
	localparam logic [3:0] CLK_CAPABLE = 4'h5;
endpackage

// ===== src/gpcd_divider.sv
/*
 Programmable clock divider for the clock output pin.
 Assumes src_tick pulses once per cycle of the 24 MHz source,
 synchronous to pclk.
*/
`timescale 1ns/1ns
module gpcd_divider #(
	parameter int DIV_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic soft_rst,
	input wire logic src_tick,
	input wire logic [DIV_W-1:0] div,
	output logic clk_level
);
	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] next_cnt;
	logic [DIV_W:0] half;

	// ==========================================================
	// Period of div+1 source ticks
	always_comb begin
		half = ({1'b0, div} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
		// New ratio taken at once; a shrunk divider restarts cleanly
		if (cnt >= div) begin
			next_cnt = '0;
		end else begin
			next_cnt = cnt + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			clk_level <= 1'b1;
		end else if (soft_rst) begin
			cnt <= '0;
			clk_level <= 1'b1;
		end else if (div == '0) begin
			cnt <= '0;
			clk_level <= 1'b0;
		end else if (div == {DIV_W{1'b1}}) begin
			cnt <= '0;
			clk_level <= 1'b1;
		end else if (src_tick) begin
			cnt <= next_cnt;
			clk_level <= ({1'b0, next_cnt} < half);
		end
	end
endmodule // gpcd_divider

// ===== src/gpcd_top.sv
/*
 Pin configuration, clock output and suspend behaviour for a group
 of four general-purpose pins, with an APB register slave.
 Assumes pin inputs and src_tick are synchronous to pclk, and that
 the pad ring resolves the wire from pin_out and pin_oe.
*/
//
// Contract
// - Open-drain pins drive low only, default off
// - Per-pin weak pull-up, default off
// - Inversion flips read and driven values
// - Drive strength selectable, low after reset
// - Clock output on one pin only
// - Only pins B0, B4 carry clock; code allows pin indices 0 and 2 (CLK_CAPABLE)
// - Suspend pin state configurable, default keep
// - Suspend permission bit, default permitted
// - Divider zero holds clock low
// - Divider all ones holds high, reset value
// - Otherwise clock is source over div+1
// - Divider change adopted without reset
// - Power-on reset plus external low reset
`timescale 1ns/1ns
module gpcd_top #(
	parameter int PIN_COUNT = gpcd_pkg::PIN_COUNT,
	parameter int DIV_W = gpcd_pkg::DIV_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_reset_n,
	input wire logic src_tick,
	input wire logic bus_suspend_req,
	output logic suspend_active,
	input wire logic [PIN_COUNT-1:0] pin_in,
	output logic [PIN_COUNT-1:0] pin_out,
	output logic [PIN_COUNT-1:0] pin_oe,
	output logic [PIN_COUNT-1:0] pin_pullup,
	output logic [PIN_COUNT-1:0] pin_drive_strong
);
	// ==========================================================
	// Address decode helpers
	function automatic logic is_pin_addr(input logic [7:0] a);
		is_pin_addr = (a[7:4] == gpcd_pkg::OFS_PIN_BASE[7:4])
			&& (a[1:0] == 2'h0);
	endfunction

	function automatic logic [1:0] pin_index(input logic [7:0] a);
		pin_index = a[3:2];
	endfunction

	// ==========================================================
	// External reset synchroniser
	logic ext_meta;
	logic ext_sync;
	logic soft_rst;

	// Second stage only feeds the logic; the first is read by the second alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= ext_reset_n;
			ext_sync <= ext_meta;
		end
	end

	// Held in reset until the external pin is released
	assign soft_rst = !ext_sync;

	// ==========================================================
	// APB phase decode
	logic apb_setup;
	logic apb_access;
	logic wr_en;
	logic addr_pin;
	logic addr_misc;
	logic addr_status;
	logic addr_ok;
	logic [1:0] widx;
	logic clk_reject;

	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable;
	assign addr_pin = is_pin_addr(paddr);
	assign addr_misc = (paddr == gpcd_pkg::OFS_MISC);
	assign addr_status = (paddr == gpcd_pkg::OFS_STATUS);
	assign addr_ok = addr_pin || addr_misc || addr_status;
	assign widx = pin_index(paddr);

	// ==========================================================
	// Configuration storage
	logic [gpcd_pkg::PC_W-1:0] pin_cfg [PIN_COUNT];
	logic [DIV_W-1:0] clk_div;
	logic susp_float;
	logic susp_allow;
	logic [PIN_COUNT-1:0] clk_sel;
	logic [PIN_COUNT-1:0] clk_others;

	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			clk_sel[i] = pin_cfg[i][gpcd_pkg::PC_CLK_SEL];
		end
		clk_others = clk_sel;
		clk_others[widx] = 1'b0;
	end

	// Clock claim refused on an incapable pin or a second owner
	always_comb begin
		clk_reject = 1'b0;
		if (addr_pin && pwdata[gpcd_pkg::PC_CLK_SEL]) begin
			if (!gpcd_pkg::CLK_CAPABLE[widx]) begin
				clk_reject = 1'b1;
			end else if (|clk_others) begin
				clk_reject = 1'b1;
			end
		end
	end

	// Refused and read-only writes leave every register untouched
	assign wr_en = apb_access && pwrite && addr_ok && !addr_status
		&& !clk_reject;

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_cfg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_cfg[g] <= gpcd_pkg::PIN_CFG_RST;
				end else if (soft_rst) begin
					pin_cfg[g] <= gpcd_pkg::PIN_CFG_RST;
				end else if (wr_en && addr_pin && widx == g) begin
					pin_cfg[g] <= pwdata[gpcd_pkg::PC_W-1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_div <= gpcd_pkg::DIV_RST;
			susp_float <= gpcd_pkg::SUSP_FLOAT_RST;
			susp_allow <= gpcd_pkg::SUSP_ALLOW_RST;
		end else if (soft_rst) begin
			clk_div <= gpcd_pkg::DIV_RST;
			susp_float <= gpcd_pkg::SUSP_FLOAT_RST;
			susp_allow <= gpcd_pkg::SUSP_ALLOW_RST;
		end else if (wr_en && addr_misc) begin
			// Divider may change at any time while running
			clk_div <= pwdata[gpcd_pkg::MC_DIV_LSB +: DIV_W];
			susp_float <= pwdata[gpcd_pkg::MC_SUSP_FLOAT];
			susp_allow <= pwdata[gpcd_pkg::MC_SUSP_ALLOW];
		end
	end

	// ==========================================================
	// Clock output generation
	logic clk_level;

	gpcd_divider #(
		.DIV_W(DIV_W)
	) u_divider (
		.pclk(pclk),
		.presetn(presetn),
		.soft_rst(soft_rst),
		.src_tick(src_tick),
		.div(clk_div),
		.clk_level(clk_level)
	);

	// ==========================================================
	// Suspend control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			suspend_active <= 1'b0;
		end else if (soft_rst) begin
			suspend_active <= 1'b0;
		end else begin
			// Request is ignored while suspend is forbidden
			suspend_active <= bus_suspend_req && susp_allow;
		end
	end

	// ==========================================================
	// Pin drive logic
	logic [PIN_COUNT-1:0] next_pin_out;
	logic [PIN_COUNT-1:0] next_pin_oe;
	logic [PIN_COUNT-1:0] pin_read;

	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_pin
			logic drive_en;
			logic level;

			// Clock owner is an output whatever its direction bit
			assign drive_en = pin_cfg[g][gpcd_pkg::PC_DIR_OUT]
				|| clk_sel[g];
			assign level = (clk_sel[g] ? clk_level
				: pin_cfg[g][gpcd_pkg::PC_OUT_VAL])
				^ pin_cfg[g][gpcd_pkg::PC_INVERT];

			always_comb begin
				if (pin_cfg[g][gpcd_pkg::PC_OPEN_DRAIN]) begin
					// Only pulls low; a high is left to the pull-up
					next_pin_out[g] = 1'b0;
					next_pin_oe[g] = drive_en && !level;
				end else begin
					next_pin_out[g] = level;
					next_pin_oe[g] = drive_en;
				end
			end

			assign pin_read[g] = pin_in[g]
				^ pin_cfg[g][gpcd_pkg::PC_INVERT];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_out[g] <= 1'b0;
					pin_oe[g] <= 1'b0;
				end else if (soft_rst) begin
					pin_out[g] <= 1'b0;
					pin_oe[g] <= 1'b0;
				end else if (!suspend_active) begin
					pin_out[g] <= next_pin_out[g];
					pin_oe[g] <= next_pin_oe[g];
				end else if (susp_float) begin
					pin_oe[g] <= 1'b0;
				end
				// Keep mode: state frozen from suspend entry
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_pullup[g] <= 1'b0;
					pin_drive_strong[g] <= 1'b0;
				end else begin
					pin_pullup[g] <=
						pin_cfg[g][gpcd_pkg::PC_PULLUP];
					pin_drive_strong[g] <=
						pin_cfg[g][gpcd_pkg::PC_DRIVE_HI];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Read data
	logic [31:0] next_prdata;
	logic [31:0] status_word;

	always_comb begin
		status_word = '0;
		status_word[gpcd_pkg::ST_PIN_LSB +: PIN_COUNT] = pin_read;
		status_word[gpcd_pkg::ST_SUSPENDED] = suspend_active;
		status_word[gpcd_pkg::ST_CLK_LEVEL] = clk_level;
		status_word[gpcd_pkg::ST_RUNNING] = ext_sync;
	end

	always_comb begin
		next_prdata = '0;
		if (addr_pin) begin
			next_prdata[gpcd_pkg::PC_W-1:0] = pin_cfg[widx];
		end else if (addr_misc) begin
			next_prdata[gpcd_pkg::MC_DIV_LSB +: DIV_W] = clk_div;
			next_prdata[gpcd_pkg::MC_SUSP_FLOAT] = susp_float;
			next_prdata[gpcd_pkg::MC_SUSP_ALLOW] = susp_allow;
		end else if (addr_status) begin
			next_prdata = status_word;
		end
	end

	// Sampled in the setup cycle so prdata leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (apb_setup && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// ==========================================================
	// Handshake: every access completes in its first access cycle
	assign pready = apb_access;

	// Errors: unmapped address, status write, refused clock claim
	always_comb begin
		pslverr = 1'b0;
		if (apb_access) begin
			if (!addr_ok) begin
				pslverr = 1'b1;
			end else if (pwrite && addr_status) begin
				pslverr = 1'b1;
			end else if (pwrite && clk_reject) begin
				pslverr = 1'b1;
			end
		end
	end
endmodule // gpcd_top
